// *** core/irc_pkg.sv ***
// Operation
// - Four external pins plus timer overflows and time base events are sources.
// - An external request comes only from its own pin's selected edge.
// - Every source has its own software enable bit.
// - A source event sets its request flag in hardware; an external pin flag needs its group enable bit set.
// - Global enable low blocks irq_req to the core from the next cycle on; irq_line is not gated by it.
// - Two-bit edge select per pin; 00 off, 01 rising, 10 falling.
// - Main control flags: counter1 bit 6, counter0 bit 5, group bit 4; bit 7 zero.
// - Main control enables: counter1 bit 3, counter0 bit 2, group bit 1, global bit 0.
// - Edge select 11 triggers on both edges.
// - Fixed priority with vectors 04H, 08H, 0CH, 10H, 14H, 18H.
// - Service clears global enable; later requests stay recorded in flags.
// - Group flag sets whenever hardware sets any external pin flag; a software write to a pin flag leaves it alone.
package irc_pkg;
   localparam logic [11:0] IRC_OFS_EDGE = 12'h000;
   localparam logic [11:0] IRC_OFS_MAIN = 12'h004;
   localparam logic [11:0] IRC_OFS_AUX = 12'h008;
   localparam logic [11:0] IRC_OFS_GROUP = 12'h00C;
   localparam logic [11:0] IRC_OFS_ISTAT = 12'h010;
   localparam logic [11:0] IRC_OFS_IMASK = 12'h014;
   localparam logic [7:0] IRC_RST_EDGE = 8'hAA;
   localparam logic [7:0] IRC_RST_MAIN = 8'h00;
   localparam logic [7:0] IRC_RST_AUX = 8'h00;
   localparam logic [7:0] IRC_RST_GROUP = 8'h00;
   localparam int IRC_B_EMI = 0;
   localparam int IRC_B_GRP_E = 1;
   localparam int IRC_B_C0_E = 2;
   localparam int IRC_B_C1_E = 3;
   localparam int IRC_B_GRP_F = 4;
   localparam int IRC_B_C0_F = 5;
   localparam int IRC_B_C1_F = 6;
   localparam int IRC_B_AD_E = 0;
   localparam int IRC_B_TB0_E = 1;
   localparam int IRC_B_TB1_E = 2;
   localparam int IRC_B_AD_F = 4;
   localparam int IRC_B_TB0_F = 5;
   localparam int IRC_B_TB1_F = 6;
   localparam logic [1:0] IRC_EDGE_OFF = 2'h0;
   localparam logic [1:0] IRC_EDGE_RISE = 2'h1;
   localparam logic [1:0] IRC_EDGE_FALL = 2'h2;
   localparam logic [1:0] IRC_EDGE_BOTH = 2'h3;
   localparam logic [7:0] IRC_VEC_GRP = 8'h04;
   localparam logic [7:0] IRC_VEC_C0 = 8'h08;
   localparam logic [7:0] IRC_VEC_C1 = 8'h0C;
   localparam logic [7:0] IRC_VEC_AD = 8'h10;
   localparam logic [7:0] IRC_VEC_TB0 = 8'h14;
   localparam logic [7:0] IRC_VEC_TB1 = 8'h18;
   localparam int IRC_NSRC = 6;
   typedef struct packed {
      logic [7:0] edge_sel;
      logic [7:0] main_ctl;
      logic [7:0] aux_ctl;
      logic [7:0] grp_ctl;
      logic [3:0] pin_prev;
      logic [1:0] ev_stat;
      logic [1:0] ev_mask;
      logic req;
      logic [7:0] vector;
      logic [31:0] prdata;
   } irc_state_t;
endpackage

// *** core/irc_top.sv ***
`timescale 1ns/1ps
module irc_top
   import irc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] ext_irq_pin,
   input wire logic counter0_overflow,
   input wire logic counter1_overflow,
   input wire logic adc_done,
   input wire logic time_base0_event,
   input wire logic time_base1_event,
   output logic irq_req,
   output logic [7:0] irq_vector,
   input wire logic irq_ack,
   output logic irq_line
);
   import irc_pkg::*;

   irc_state_t s;
   irc_state_t next_s;
   logic wr;
   logic rd;
   logic map_hit;
   logic [3:0] pin_evt;
   logic [5:0] flags;
   logic [5:0] enables;
   logic [5:0] pending;
   logic [5:0] ack_clr;
   logic [5:0] win;
   logic [7:0] w8;

   function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
      edge_hit = ((sel == IRC_EDGE_RISE || sel == IRC_EDGE_BOTH) && !prev && cur)
         || ((sel == IRC_EDGE_FALL || sel == IRC_EDGE_BOTH) && prev && !cur);
   endfunction

   // Lowest set bit wins, so the group source has top priority
   function automatic logic [5:0] first_one(input logic [5:0] v);
      first_one = v & (~v + 6'h01);
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign w8 = pwdata[7:0];
   assign map_hit = paddr == IRC_OFS_EDGE || paddr == IRC_OFS_MAIN || paddr == IRC_OFS_AUX
      || paddr == IRC_OFS_GROUP || paddr == IRC_OFS_ISTAT || paddr == IRC_OFS_IMASK;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_evt[i] = edge_hit(s.edge_sel[2*i +: 2], s.pin_prev[i], ext_irq_pin[i]);
      end
   end

   assign flags = {s.aux_ctl[IRC_B_TB1_F], s.aux_ctl[IRC_B_TB0_F], s.aux_ctl[IRC_B_AD_F],
      s.main_ctl[IRC_B_C1_F], s.main_ctl[IRC_B_C0_F], s.main_ctl[IRC_B_GRP_F]};
   assign enables = {s.aux_ctl[IRC_B_TB1_E], s.aux_ctl[IRC_B_TB0_E], s.aux_ctl[IRC_B_AD_E],
      s.main_ctl[IRC_B_C1_E], s.main_ctl[IRC_B_C0_E], s.main_ctl[IRC_B_GRP_E]};
   assign pending = flags & enables & {IRC_NSRC{s.main_ctl[IRC_B_EMI]}};
   assign win = first_one(pending);
   // The acknowledge clears the flag of a re-evaluated winner among flags and enables, not of the vector presented
   assign ack_clr = (irq_ack && s.req) ? first_one(flags & enables) : 6'h00;

   always_comb begin
      next_s = s;
      next_s.pin_prev = ext_irq_pin;
      next_s.prdata = 32'h0000_0000;
      if (rd) begin
         unique case (paddr)
            IRC_OFS_EDGE: next_s.prdata = {24'h000000, s.edge_sel};
            IRC_OFS_MAIN: next_s.prdata = {24'h000000, s.main_ctl};
            IRC_OFS_AUX: next_s.prdata = {24'h000000, s.aux_ctl};
            IRC_OFS_GROUP: next_s.prdata = {24'h000000, s.grp_ctl};
            IRC_OFS_ISTAT: next_s.prdata = {30'h00000000, s.ev_stat};
            IRC_OFS_IMASK: next_s.prdata = {30'h00000000, s.ev_mask};
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end
      // Software writes first, hardware sets after, so a coincident event wins
      if (wr) begin
         unique case (paddr)
            IRC_OFS_EDGE: next_s.edge_sel = w8;
            IRC_OFS_MAIN: next_s.main_ctl = {1'b0, w8[6:0]};
            IRC_OFS_AUX: next_s.aux_ctl = {1'b0, w8[6:4], 1'b0, w8[2:0]};
            IRC_OFS_GROUP: next_s.grp_ctl = w8;
            IRC_OFS_ISTAT: next_s.ev_stat = s.ev_stat & ~w8[1:0];
            IRC_OFS_IMASK: next_s.ev_mask = w8[1:0];
            default: ;
         endcase
      end
      if (irq_ack && s.req) begin
         next_s.main_ctl[IRC_B_EMI] = 1'b0;
         next_s.main_ctl[IRC_B_GRP_F] = next_s.main_ctl[IRC_B_GRP_F] & ~ack_clr[0];
         next_s.main_ctl[IRC_B_C0_F] = next_s.main_ctl[IRC_B_C0_F] & ~ack_clr[1];
         next_s.main_ctl[IRC_B_C1_F] = next_s.main_ctl[IRC_B_C1_F] & ~ack_clr[2];
         next_s.aux_ctl[IRC_B_AD_F] = next_s.aux_ctl[IRC_B_AD_F] & ~ack_clr[3];
         next_s.aux_ctl[IRC_B_TB0_F] = next_s.aux_ctl[IRC_B_TB0_F] & ~ack_clr[4];
         next_s.aux_ctl[IRC_B_TB1_F] = next_s.aux_ctl[IRC_B_TB1_F] & ~ack_clr[5];
      end
      for (int i = 0; i < 4; i++) begin
         // Pin flag latches only with its own enable set, matching the pin-function gate
         if (pin_evt[i] && s.grp_ctl[i]) begin
            next_s.grp_ctl[4 + i] = 1'b1;
            next_s.main_ctl[IRC_B_GRP_F] = 1'b1;
         end
      end
      if (counter0_overflow) next_s.main_ctl[IRC_B_C0_F] = 1'b1;
      if (counter1_overflow) next_s.main_ctl[IRC_B_C1_F] = 1'b1;
      if (adc_done) next_s.aux_ctl[IRC_B_AD_F] = 1'b1;
      if (time_base0_event) next_s.aux_ctl[IRC_B_TB0_F] = 1'b1;
      if (time_base1_event) next_s.aux_ctl[IRC_B_TB1_F] = 1'b1;
      if (irq_ack && s.req) next_s.ev_stat[0] = 1'b1;
      if (|pin_evt) next_s.ev_stat[1] = 1'b1;
      next_s.req = |win && !(irq_ack && s.req);
      unique case (1'b1)
         win[0]: next_s.vector = IRC_VEC_GRP;
         win[1]: next_s.vector = IRC_VEC_C0;
         win[2]: next_s.vector = IRC_VEC_C1;
         win[3]: next_s.vector = IRC_VEC_AD;
         win[4]: next_s.vector = IRC_VEC_TB0;
         win[5]: next_s.vector = IRC_VEC_TB1;
         default: next_s.vector = s.vector;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
         s.edge_sel <= IRC_RST_EDGE;
         s.main_ctl <= IRC_RST_MAIN;
         s.aux_ctl <= IRC_RST_AUX;
         s.grp_ctl <= IRC_RST_GROUP;
         // Pins idle low assumed at reset, first edge seen one cycle after release
      end else begin
         s <= next_s;
      end
   end

   assign pready = psel && penable;
   assign pslverr = psel && penable && !map_hit;
   assign prdata = s.prdata;
   assign irq_req = s.req;
   assign irq_vector = s.vector;
   assign irq_line = |(s.ev_stat & s.ev_mask);

   a_no_req_no_emi: assert property (@(posedge core_clk) disable iff (rst)
      !$past(s.main_ctl[IRC_B_EMI]) && !$past(rst) |-> !irq_req)
      else $error("request raised while global enable was low");
   a_ack_clears_emi: assert property (@(posedge core_clk) disable iff (rst)
      irq_ack && irq_req && !(wr && paddr == IRC_OFS_MAIN) |=> !s.main_ctl[IRC_B_EMI])
      else $error("global enable not cleared by service");
   a_c0_flag_sets: assert property (@(posedge core_clk) disable iff (rst)
      counter0_overflow |=> s.main_ctl[IRC_B_C0_F])
      else $error("counter0 flag not set");
   a_rise_sets_pin: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[1:0] == IRC_EDGE_RISE && s.grp_ctl[0] && !s.pin_prev[0] && ext_irq_pin[0]
      |=> s.grp_ctl[4] && s.main_ctl[IRC_B_GRP_F])
      else $error("rising edge on pin 0 not recorded");
   a_off_no_pin: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[1:0] == IRC_EDGE_OFF |-> !pin_evt[0])
      else $error("disabled pin produced an event");
   a_both_fall: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[3:2] == IRC_EDGE_BOTH && s.pin_prev[1] && !ext_irq_pin[1] |-> pin_evt[1])
      else $error("both-edge mode missed a fall");
   a_group_prio: assert property (@(posedge core_clk) disable iff (rst)
      pending[0] && !(irq_ack && s.req) |=> irq_req && irq_vector == IRC_VEC_GRP)
      else $error("group source not given priority");
   a_need_enable: assert property (@(posedge core_clk) disable iff (rst)
      irq_req && irq_vector == IRC_VEC_C1 |-> $past(s.main_ctl[IRC_B_C1_E]) && $past(s.main_ctl[IRC_B_C1_F]))
      else $error("counter1 request without flag and enable");
   a_flag_holds: assert property (@(posedge core_clk) disable iff (rst)
      s.main_ctl[IRC_B_C0_F] && !irq_ack && !wr |=> s.main_ctl[IRC_B_C0_F])
      else $error("counter0 flag dropped without clear");
   a_bit7_zero: assert property (@(posedge core_clk) disable iff (rst)
      !s.main_ctl[7]) else $error("main control bit 7 not zero");

   a_c1_flag_sets: assert property (@(posedge core_clk) disable iff (rst)
      counter1_overflow |=> s.main_ctl[IRC_B_C1_F])
      else $error("counter1 flag not set");
   a_ad_flag_sets: assert property (@(posedge core_clk) disable iff (rst)
      adc_done |=> s.aux_ctl[IRC_B_AD_F])
      else $error("converter flag not set");
   a_tb0_flag_sets: assert property (@(posedge core_clk) disable iff (rst)
      time_base0_event |=> s.aux_ctl[IRC_B_TB0_F])
      else $error("time base 0 flag not set");
   a_tb1_flag_sets: assert property (@(posedge core_clk) disable iff (rst)
      time_base1_event |=> s.aux_ctl[IRC_B_TB1_F])
      else $error("time base 1 flag not set");
   a_aux_gaps_zero: assert property (@(posedge core_clk) disable iff (rst)
      !s.aux_ctl[7] && !s.aux_ctl[3])
      else $error("aux control unused bit set");
   a_rise_pin1: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[3:2] == IRC_EDGE_RISE && s.grp_ctl[1] && !s.pin_prev[1] && ext_irq_pin[1]
      |=> s.grp_ctl[5] && s.main_ctl[IRC_B_GRP_F])
      else $error("rising edge on pin 1 not recorded");
   a_rise_pin2: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[5:4] == IRC_EDGE_RISE && s.grp_ctl[2] && !s.pin_prev[2] && ext_irq_pin[2]
      |=> s.grp_ctl[6] && s.main_ctl[IRC_B_GRP_F])
      else $error("rising edge on pin 2 not recorded");
   a_rise_pin3: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[7:6] == IRC_EDGE_RISE && s.grp_ctl[3] && !s.pin_prev[3] && ext_irq_pin[3]
      |=> s.grp_ctl[7] && s.main_ctl[IRC_B_GRP_F])
      else $error("rising edge on pin 3 not recorded");
   a_fall_pin0: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[1:0] == IRC_EDGE_FALL && s.grp_ctl[0] && s.pin_prev[0] && !ext_irq_pin[0]
      |=> s.grp_ctl[4] && s.main_ctl[IRC_B_GRP_F])
      else $error("falling edge on pin 0 not recorded");
   a_fall_pin1: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[3:2] == IRC_EDGE_FALL && s.grp_ctl[1] && s.pin_prev[1] && !ext_irq_pin[1]
      |=> s.grp_ctl[5] && s.main_ctl[IRC_B_GRP_F])
      else $error("falling edge on pin 1 not recorded");
   a_fall_pin2: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[5:4] == IRC_EDGE_FALL && s.grp_ctl[2] && s.pin_prev[2] && !ext_irq_pin[2]
      |=> s.grp_ctl[6] && s.main_ctl[IRC_B_GRP_F])
      else $error("falling edge on pin 2 not recorded");
   a_fall_pin3: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[7:6] == IRC_EDGE_FALL && s.grp_ctl[3] && s.pin_prev[3] && !ext_irq_pin[3]
      |=> s.grp_ctl[7] && s.main_ctl[IRC_B_GRP_F])
      else $error("falling edge on pin 3 not recorded");
   a_off_no_pin1: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[3:2] == IRC_EDGE_OFF |-> !pin_evt[1])
      else $error("disabled pin 1 produced an event");
   a_off_no_pin2: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[5:4] == IRC_EDGE_OFF |-> !pin_evt[2])
      else $error("disabled pin 2 produced an event");
   a_off_no_pin3: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[7:6] == IRC_EDGE_OFF |-> !pin_evt[3])
      else $error("disabled pin 3 produced an event");
   a_both_rise: assert property (@(posedge core_clk) disable iff (rst)
      s.edge_sel[3:2] == IRC_EDGE_BOTH && !s.pin_prev[1] && ext_irq_pin[1] |-> pin_evt[1])
      else $error("both-edge mode missed a rise");
   a_c0_prio: assert property (@(posedge core_clk) disable iff (rst)
      pending[1] && !pending[0] && !(irq_ack && s.req) |=> irq_req && irq_vector == IRC_VEC_C0)
      else $error("counter0 vector wrong");
   a_c1_prio: assert property (@(posedge core_clk) disable iff (rst)
      pending[2] && pending[1:0] == 2'h0 && !(irq_ack && s.req) |=> irq_req && irq_vector == IRC_VEC_C1)
      else $error("counter1 vector wrong");
   a_ad_prio: assert property (@(posedge core_clk) disable iff (rst)
      pending[3] && pending[2:0] == 3'h0 && !(irq_ack && s.req) |=> irq_req && irq_vector == IRC_VEC_AD)
      else $error("converter vector wrong");
   a_tb0_prio: assert property (@(posedge core_clk) disable iff (rst)
      pending[4] && pending[3:0] == 4'h0 && !(irq_ack && s.req) |=> irq_req && irq_vector == IRC_VEC_TB0)
      else $error("time base 0 vector wrong");
   a_tb1_prio: assert property (@(posedge core_clk) disable iff (rst)
      pending[5] && pending[4:0] == 5'h00 && !(irq_ack && s.req) |=> irq_req && irq_vector == IRC_VEC_TB1)
      else $error("time base 1 vector wrong");
   a_no_pend_no_req: assert property (@(posedge core_clk) disable iff (rst)
      pending == 6'h00 |=> !irq_req)
      else $error("request without a pending source");
   a_ack_drops_req: assert property (@(posedge core_clk) disable iff (rst)
      irq_ack && irq_req |=> !irq_req)
      else $error("request held after service");
   a_ack_clears_c0: assert property (@(posedge core_clk) disable iff (rst)
      irq_ack && irq_req && irq_vector == IRC_VEC_C0 && !flags[0] && !counter0_overflow
      && !(wr && paddr == IRC_OFS_MAIN) |=> !s.main_ctl[IRC_B_C0_F])
      else $error("served counter0 flag not cleared");
   a_group_follows_pin: assert property (@(posedge core_clk) disable iff (rst)
      $rose(s.grp_ctl[4]) && !$past(wr && paddr == IRC_OFS_GROUP) |-> s.main_ctl[IRC_B_GRP_F])
      else $error("pin 0 flag set without group flag");
   a_ack_sets_stat: assert property (@(posedge core_clk) disable iff (rst)
      irq_ack && irq_req |=> s.ev_stat[0])
      else $error("service status not recorded");
   a_ready_access: assert property (@(posedge core_clk) disable iff (rst)
      psel && penable |-> pready)
      else $error("access phase without ready");
   a_err_unmapped: assert property (@(posedge core_clk) disable iff (rst)
      psel && penable && paddr == 12'hFF0 |-> pslverr)
      else $error("unmapped access without error");

   c_group_served: cover property (@(posedge core_clk) irq_req && irq_vector == IRC_VEC_GRP ##1 irq_ack);
   c_ad_served: cover property (@(posedge core_clk) irq_req && irq_vector == IRC_VEC_AD && irq_ack);
   c_tb1_served: cover property (@(posedge core_clk) irq_req && irq_vector == IRC_VEC_TB1 && irq_ack);
   c_line_up: cover property (@(posedge core_clk) irq_line);
endmodule

// *** testbench/irc_core_model.sv ***
`timescale 1ns/1ps
module irc_core_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic [2:0] ack_delay,
   output logic irq_ack
);
   logic [2:0] wait_cnt;
   initial irq_ack = 1'b0;
   // A slow answer leaves room for late requests to pile up in their flags
   always @(posedge core_clk) begin
      irq_ack <= 1'b0;
      if (rst) begin
         wait_cnt <= 3'h0;
      end else if (irq_req && !irq_ack) begin
         if (wait_cnt >= ack_delay) begin
            irq_ack <= 1'b1;
            wait_cnt <= 3'h0;
         end else begin
            wait_cnt <= wait_cnt + 3'h1;
         end
      end
   end
endmodule

// *** testbench/interrupt_request_control_tb.sv ***
`timescale 1ns/1ps
module interrupt_request_control_tb;
   import irc_pkg::*;
   logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, req_d = 0;
   logic c0_ev = 0, c1_ev = 0, ad_ev = 0, tb0_ev = 0, tb1_ev = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [3:0] ext_irq_pin = 0;
   logic [2:0] ack_delay = 0;
   logic pready, pslverr, irq_req, irq_ack, irq_line;
   logic [7:0] irq_vector;
   logic [32:0] rd_q[$];
   logic [7:0] vec_q[$];
   int error_cnt = 0, comparisons = 0;
   always #2 core_clk = ~core_clk;
   irc_top irc_top_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq_pin(ext_irq_pin), .counter0_overflow(c0_ev), .counter1_overflow(c1_ev), .adc_done(ad_ev),
      .time_base0_event(tb0_ev), .time_base1_event(tb1_ev), .irq_req(irq_req), .irq_vector(irq_vector),
      .irq_ack(irq_ack), .irq_line(irq_line));
   irc_core_model irc_core_model_inst (.core_clk(core_clk), .rst(rst), .irq_req(irq_req),
      .ack_delay(ack_delay), .irq_ack(irq_ack));
   task tally_and_finish;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task check(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk) penable <= 1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task rd(input logic [11:0] a, input logic [32:0] exp);
      rd_q.push_back(exp);
      apb(a, 1'b0, 32'h0);
   endtask
   task evt(input logic [4:0] w);
      c0_ev <= w[0];
      c1_ev <= w[1];
      ad_ev <= w[2];
      tb0_ev <= w[3];
      tb1_ev <= w[4];
      @(posedge core_clk);
      c0_ev <= 0;
      c1_ev <= 0;
      ad_ev <= 0;
      tb0_ev <= 0;
      tb1_ev <= 0;
      @(posedge core_clk);
   endtask
   task served;
      for (int i = 0; i < 40 && irq_ack !== 1'b1; i++) @(posedge core_clk);
      check({32'h0, irq_ack}, 33'h1);
      @(posedge core_clk);
      ack_delay <= 3'($urandom % 8);
   endtask
   // Results are compared in the order they were promised
   always @(posedge core_clk) begin
      req_d <= irq_req;
      if (psel && penable && pready && !pwrite) check({pslverr, prdata}, rd_q.pop_front());
      if (irq_req && !req_d) check({25'h0, irq_vector}, {25'h0, vec_q.pop_front()});
   end
   initial begin
      #40000;
      error_cnt++;
      $display("mismatch at %0t: run hung", $time);
      tally_and_finish;
   end
   initial begin
      int p;
      logic [1:0] m;
      void'($urandom(32'hBA73E939));
      repeat (12) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      rd(IRC_OFS_EDGE, {25'h0, IRC_RST_EDGE});
      rd(IRC_OFS_MAIN, {25'h0, IRC_RST_MAIN});
      rd(12'hFF0, 33'h1_0000_0000);
      wr(IRC_OFS_MAIN, 32'h05);
      vec_q.push_back(IRC_VEC_C0);
      evt(5'b00001);
      served;
      rd(IRC_OFS_MAIN, 33'h04);
      wr(IRC_OFS_MAIN, 32'h0C);
      evt(5'b00011);
      repeat (3) @(posedge core_clk);
      check({32'h0, irq_req}, 33'h0);
      rd(IRC_OFS_MAIN, 33'h6C);
      vec_q.push_back(IRC_VEC_C0);
      vec_q.push_back(IRC_VEC_C1);
      wr(IRC_OFS_MAIN, 32'h6D);
      served;
      rd(IRC_OFS_MAIN, 33'h4C);
      wr(IRC_OFS_MAIN, 32'h4D);
      served;
      rd(IRC_OFS_MAIN, 33'h0C);
      vec_q.push_back(IRC_VEC_C0);
      wr(IRC_OFS_MAIN, 32'h25);
      served;
      wr(IRC_OFS_IMASK, 32'h2);
      for (int k = 0; k < 4; k++) begin
         m = 2'(k);
         p = $urandom % 4;
         wr(IRC_OFS_EDGE, 32'(m) << (2 * p));
         wr(IRC_OFS_GROUP, 32'h1 << p);
         wr(IRC_OFS_MAIN, 32'h0);
         ext_irq_pin[p] <= 1;
         repeat (2) @(posedge core_clk);
         rd(IRC_OFS_GROUP, {1'b0, (32'h1 << p) | (32'(m[0]) << (4 + p))});
         rd(IRC_OFS_MAIN, {1'b0, 32'(m[0]) << 4});
         if (m[0]) begin
            check({32'h0, irq_line}, 33'h1);
            wr(IRC_OFS_ISTAT, 32'h2);
            check({32'h0, irq_line}, 33'h0);
         end
         wr(IRC_OFS_GROUP, 32'h1 << p);
         ext_irq_pin[p] <= 0;
         repeat (2) @(posedge core_clk);
         rd(IRC_OFS_GROUP, {1'b0, (32'h1 << p) | (32'(m[1]) << (4 + p))});
      end
      vec_q.push_back(IRC_VEC_GRP);
      wr(IRC_OFS_MAIN, 32'h13);
      served;
      wr(IRC_OFS_AUX, 32'h07);
      evt(5'b11100);
      rd(IRC_OFS_AUX, 33'h77);
      vec_q.push_back(IRC_VEC_AD);
      vec_q.push_back(IRC_VEC_TB0);
      vec_q.push_back(IRC_VEC_TB1);
      wr(IRC_OFS_MAIN, 32'h01);
      served;
      wr(IRC_OFS_MAIN, 32'h01);
      served;
      wr(IRC_OFS_MAIN, 32'h01);
      served;
      rd(IRC_OFS_AUX, 33'h07);
      check(33'(vec_q.size() + rd_q.size()), 33'h0);
      tally_and_finish;
   end
endmodule
